// [pkg/rmode_pkg.sv]
// Package of encodings, state counts and constants for the addressing-mode decode unit.
package rmode_pkg;
  localparam logic [15:0] OPC_IDX_MASK   = 16'hF00F;
  localparam logic [15:0] OPC_ST_IDX_B   = 16'h0004;
  localparam logic [15:0] OPC_ST_IDX_W   = 16'h0005;
  localparam logic [15:0] OPC_ST_IDX_L   = 16'h0006;
  localparam logic [15:0] OPC_LD_IDX_B   = 16'h000C;
  localparam logic [15:0] OPC_LD_IDX_W   = 16'h000D;
  localparam logic [15:0] OPC_LD_IDX_L   = 16'h000E;
  localparam logic [15:0] OPC_REG_MASK   = 16'hF0FF;
  localparam logic [15:0] OPC_JMP_REL    = 16'h0023;
  localparam logic [15:0] OPC_CALL_REL   = 16'h0003;
  localparam logic [7:0]  OPC_ST_GB_B    = 8'hC0;
  localparam logic [7:0]  OPC_ST_GB_W    = 8'hC1;
  localparam logic [7:0]  OPC_ST_GB_L    = 8'hC2;
  localparam logic [7:0]  OPC_TRAP       = 8'hC3;
  localparam logic [7:0]  OPC_LD_GB_B    = 8'hC4;
  localparam logic [7:0]  OPC_LD_GB_W    = 8'hC5;
  localparam logic [7:0]  OPC_LD_GB_L    = 8'hC6;
  localparam logic [7:0]  OPC_ADDR_LIT   = 8'hC7;
  localparam logic [7:0]  OPC_TST_IMM    = 8'hC8;
  localparam logic [7:0]  OPC_AND_IMM    = 8'hC9;
  localparam logic [7:0]  OPC_XOR_IMM    = 8'hCA;
  localparam logic [7:0]  OPC_OR_IMM     = 8'hCB;
  localparam logic [7:0]  OPC_TST_MEM    = 8'hCC;
  localparam logic [7:0]  OPC_AND_MEM    = 8'hCD;
  localparam logic [7:0]  OPC_XOR_MEM    = 8'hCE;
  localparam logic [7:0]  OPC_OR_MEM     = 8'hCF;
  localparam logic [7:0]  OPC_COMPARE_EQUAL     = 8'h88;
  localparam logic [7:0]  OPC_BR_T       = 8'h89;
  localparam logic [7:0]  OPC_BR_F       = 8'h8B;
  localparam logic [7:0]  OPC_BR_T_DLY   = 8'h8D;
  localparam logic [7:0]  OPC_BR_F_DLY   = 8'h8F;
  localparam logic [3:0]  OPC_LD_PC_W    = 4'h9;
  localparam logic [3:0]  OPC_LD_PC_L    = 4'hD;
  localparam logic [3:0]  OPC_JUMP_DISP  = 4'hA;
  localparam logic [3:0]  OPC_CALL_DISP  = 4'hB;
  localparam logic [3:0]  OPC_ADD_IMM    = 4'h7;
  localparam logic [3:0]  OPC_MOV_IMM    = 4'hE;
  // Access sizes on the memory port.
  localparam logic [1:0]  SZ_BYTE        = 2'h0;
  localparam logic [1:0]  SZ_WORD        = 2'h1;
  localparam logic [1:0]  SZ_LONG        = 2'h2;
  // Execution state counts.
  localparam logic [3:0]  ST_ONE         = 4'h1;
  localparam logic [3:0]  ST_DELAYED     = 4'h2;
  localparam logic [3:0]  ST_RMW         = 4'h3;
  localparam logic [3:0]  ST_BRANCH      = 4'h3;
  localparam logic [3:0]  ST_TRAP        = 4'h8;
  localparam logic [31:0] LONG_STEP      = 32'h0000_0004;
  localparam logic [3:0]  IDX_ZERO       = 4'h0;
endpackage : rmode_pkg

// [rtl/rmode_decode.sv]
// Decode and execute unit for indexed, base, PC-relative, branch, immediate and trap forms.
// What this block does
// - Indexed store source to zero plus target.
// - Indexed load sign-extends byte and word.
// - Base store scales offset by size.
// - Base load into zero, sign-extend narrow.
// - Byte AND read-modify-write, three states.
// - Byte test sets flag, no write.
// - Byte XOR and OR modify, flag kept.
// - PC word load, sign-extended, two states.
// - PC longword load into target register.
// - Address of literal into zero register.
// - Register-relative jump and call, delayed.
// - Newer variant only for those encodings.
// - Conditional branch: three taken, one not.
// - Delayed conditional branch, newer variant only: two taken, one not.
// - Unconditional relative jump, delayed, two states.
// - Relative call saves return, two states.
// - Immediate add into target register.
// - Immediate logic on zero, flag kept.
// - Compare equal literal sets flag.
// - Immediate transfer sign-extends literal.
// - Immediate test sets flag on zero.
// - Trap pushes PC and status, vectors.
`timescale 1ns/100ps
`default_nettype none
module rmode_decode
  import rmode_pkg::*;
#(
  parameter bit NEWER_VARIANT = 1'b1
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // Instruction issue.
  input  wire logic        INSN_VALID,
  input  wire logic [15:0] INSN,
  input  wire logic [31:0] PC_IN,
  // Register file read values and core registers.
  input  wire logic [31:0] SOURCE_VAL,
  input  wire logic [31:0] TARGET_VAL,
  input  wire logic [31:0] ZERO_VAL,
  input  wire logic [31:0] GLOBAL_BASE,
  input  wire logic [31:0] VECTOR_BASE,
  input  wire logic [31:0] STACK_PTR,
  input  wire logic [31:0] STATUS_VAL,
  // Memory read data, valid in the cycle after a read request.
  input  wire logic [31:0] MEM_RDATA,
  // Memory request.
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic [1:0]       MEM_SIZE,
  output logic [31:0]      MEM_ADDR,
  output logic [31:0]      MEM_WDATA,
  // Register write back.
  output logic             REG_WE,
  output logic [3:0]       REG_IDX,
  output logic [31:0]      REG_WDATA,
  output logic             RET_WE,
  output logic [31:0]      RET_WDATA,
  output logic             SP_WE,
  output logic [31:0]      SP_WDATA,
  // Flow control and status.
  output logic             PC_WE,
  output logic [31:0]      PC_WDATA,
  output logic             DELAY_SLOT,
  output logic             FLAG_Q,
  output logic             BUSY,
  output logic             ILLEGAL
);
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_RMW_RD, S_RMW_WR, S_WAIT, S_TRAP} state_e;
  typedef struct packed {
    state_e      st;
    logic [3:0]  cnt;
    logic        ld_sext;
    logic [1:0]  ld_size;
    logic [3:0]  ld_idx;
    logic [1:0]  rmw_op;
    logic [7:0]  lit;
    logic [31:0] tmp;
    logic        mem_req;
    logic        mem_we;
    logic [1:0]  mem_size;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        reg_we;
    logic [3:0]  reg_idx;
    logic [31:0] reg_wdata;
    logic        ret_we;
    logic [31:0] ret_wdata;
    logic        sp_we;
    logic [31:0] sp_wdata;
    logic        pc_we;
    logic [31:0] pc_wdata;
    logic        delay_slot;
    logic        flag;
    logic        illegal;
    logic        busy;
  } core_s;
  core_s q, d;

  logic [3:0]  fn;
  logic [7:0]  hi8;
  logic [31:0] off8_u, off8_s, off12_s, lit_s, gb_ofs, rmw_addr;
  logic [7:0]  rmw_res;

  // Field extraction; data offsets are zero-extended, branch offsets sign-extended.
  assign fn       = INSN[11:8];
  assign hi8      = INSN[15:8];
  assign off8_u   = {24'h000000, INSN[7:0]};
  assign off8_s   = {{24{INSN[7]}}, INSN[7:0]};
  assign off12_s  = {{20{INSN[11]}}, INSN[11:0]};
  assign lit_s    = {{24{INSN[7]}}, INSN[7:0]};
  assign gb_ofs   = GLOBAL_BASE + (off8_u << INSN[9:8]);
  assign rmw_addr = ZERO_VAL + GLOBAL_BASE;

  // Modify step of the byte read-modify-write forms.
  always_comb begin
    case (q.rmw_op)
      2'h1:    rmw_res = MEM_RDATA[7:0] & q.lit;
      2'h2:    rmw_res = MEM_RDATA[7:0] ^ q.lit;
      2'h3:    rmw_res = MEM_RDATA[7:0] | q.lit;
      default: rmw_res = MEM_RDATA[7:0] & q.lit;
    endcase
  end

  // Next-state logic; strobes fall back to zero each cycle so they act as pulses.
  always_comb begin
    d            = q;
    d.mem_req    = 1'b0;
    d.mem_we     = 1'b0;
    d.reg_we     = 1'b0;
    d.ret_we     = 1'b0;
    d.sp_we      = 1'b0;
    d.pc_we      = 1'b0;
    d.delay_slot = 1'b0;
    d.illegal    = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (INSN_VALID) begin
          d.cnt = ST_ONE;
          if (((INSN & OPC_IDX_MASK) == OPC_ST_IDX_B) || ((INSN & OPC_IDX_MASK) == OPC_ST_IDX_W)
              || ((INSN & OPC_IDX_MASK) == OPC_ST_IDX_L)) begin
            d.mem_req   = 1'b1;
            d.mem_we    = 1'b1;
            d.mem_size  = INSN[1:0];
            d.mem_addr  = ZERO_VAL + TARGET_VAL;
            d.mem_wdata = SOURCE_VAL;
          end else if (((INSN & OPC_IDX_MASK) == OPC_LD_IDX_B)
              || ((INSN & OPC_IDX_MASK) == OPC_LD_IDX_W)
              || ((INSN & OPC_IDX_MASK) == OPC_LD_IDX_L)) begin
            d.mem_req  = 1'b1;
            d.mem_size = INSN[1:0];
            d.mem_addr = ZERO_VAL + SOURCE_VAL;
            d.ld_size  = INSN[1:0];
            d.ld_sext  = (INSN[1:0] != SZ_LONG);
            d.ld_idx   = fn;
            d.st       = S_LOAD;
          end else if ((INSN & OPC_REG_MASK) == OPC_JMP_REL
              || (INSN & OPC_REG_MASK) == OPC_CALL_REL) begin
            if (NEWER_VARIANT) begin
              d.pc_we      = 1'b1;
              d.pc_wdata   = TARGET_VAL + PC_IN;
              d.delay_slot = 1'b1;
              d.ret_we     = ~INSN[5];
              d.ret_wdata  = PC_IN;
              d.cnt        = ST_DELAYED - ST_ONE;
              d.st         = S_WAIT;
            end else begin
              d.illegal = 1'b1;
            end
          end else if (hi8 == OPC_ST_GB_B || hi8 == OPC_ST_GB_W || hi8 == OPC_ST_GB_L) begin
            d.mem_req   = 1'b1;
            d.mem_we    = 1'b1;
            d.mem_size  = INSN[9:8];
            d.mem_addr  = gb_ofs;
            d.mem_wdata = ZERO_VAL;
          end else if (hi8 == OPC_LD_GB_B || hi8 == OPC_LD_GB_W || hi8 == OPC_LD_GB_L) begin
            d.mem_req  = 1'b1;
            d.mem_size = INSN[9:8];
            d.mem_addr = gb_ofs;
            d.ld_size  = INSN[9:8];
            d.ld_sext  = (INSN[9:8] != SZ_LONG);
            d.ld_idx   = IDX_ZERO;
            d.st       = S_LOAD;
          end else if (hi8 == OPC_AND_MEM || hi8 == OPC_TST_MEM || hi8 == OPC_XOR_MEM
              || hi8 == OPC_OR_MEM) begin
            d.mem_req  = 1'b1;
            d.mem_size = SZ_BYTE;
            d.mem_addr = rmw_addr;
            d.lit      = INSN[7:0];
            d.rmw_op   = INSN[9:8];
            d.st       = S_RMW_RD;
          end else if (INSN[15:12] == OPC_LD_PC_W || INSN[15:12] == OPC_LD_PC_L) begin
            d.mem_req  = 1'b1;
            d.mem_size = INSN[14] ? SZ_LONG : SZ_WORD;
            d.mem_addr = PC_IN + (INSN[14] ? (off8_u << 2) : (off8_u << 1));
            d.ld_size  = d.mem_size;
            d.ld_sext  = ~INSN[14];
            d.ld_idx   = fn;
            d.st       = S_LOAD;
          end else if (hi8 == OPC_ADDR_LIT) begin
            d.reg_we    = 1'b1;
            d.reg_idx   = IDX_ZERO;
            d.reg_wdata = PC_IN + (off8_u << 2);
          end else if (hi8 == OPC_BR_T || hi8 == OPC_BR_F || hi8 == OPC_BR_T_DLY
              || hi8 == OPC_BR_F_DLY) begin
            if (INSN[10] && !NEWER_VARIANT) begin
              d.illegal = 1'b1;
            end else if (q.flag == ~INSN[9]) begin
              d.pc_we      = 1'b1;
              d.pc_wdata   = PC_IN + (off8_s << 1);
              d.delay_slot = INSN[10];
              d.cnt        = (INSN[10] ? ST_DELAYED : ST_BRANCH) - ST_ONE;
              d.st         = S_WAIT;
            end
          end else if (INSN[15:12] == OPC_JUMP_DISP || INSN[15:12] == OPC_CALL_DISP) begin
            d.pc_we      = 1'b1;
            d.pc_wdata   = PC_IN + (off12_s << 1);
            d.delay_slot = 1'b1;
            d.ret_we     = INSN[12];
            d.ret_wdata  = PC_IN;
            d.cnt        = ST_DELAYED - ST_ONE;
            d.st         = S_WAIT;
          end else if (INSN[15:12] == OPC_ADD_IMM) begin
            d.reg_we    = 1'b1;
            d.reg_idx   = fn;
            d.reg_wdata = TARGET_VAL + lit_s;
          end else if (INSN[15:12] == OPC_MOV_IMM) begin
            d.reg_we    = 1'b1;
            d.reg_idx   = fn;
            d.reg_wdata = lit_s;
          end else if (hi8 == OPC_AND_IMM || hi8 == OPC_XOR_IMM || hi8 == OPC_OR_IMM) begin
            d.reg_we  = 1'b1;
            d.reg_idx = IDX_ZERO;
            d.reg_wdata = (hi8 == OPC_AND_IMM) ? (ZERO_VAL & off8_u)
                        : (hi8 == OPC_XOR_IMM) ? (ZERO_VAL ^ off8_u) : (ZERO_VAL | off8_u);
          end else if (hi8 == OPC_COMPARE_EQUAL) begin
            d.flag = (ZERO_VAL == lit_s);
          end else if (hi8 == OPC_TST_IMM) begin
            d.flag = ((ZERO_VAL & off8_u) == 32'h0000_0000);
          end else if (hi8 == OPC_TRAP) begin
            // Status goes first, the return PC second, then the vector is fetched.
            d.mem_req   = 1'b1;
            d.mem_we    = 1'b1;
            d.mem_size  = SZ_LONG;
            d.mem_addr  = STACK_PTR - LONG_STEP;
            d.mem_wdata = STATUS_VAL;
            d.tmp       = PC_IN;
            d.lit       = INSN[7:0];
            d.cnt       = ST_ONE;
            d.st        = S_TRAP;
          end else begin
            d.illegal = 1'b1;
          end
        end
      end
      S_LOAD: begin
        // Narrow loads sign-extend; longwords pass unchanged.
        d.reg_we  = 1'b1;
        d.reg_idx = q.ld_idx;
        case (q.ld_size)
          SZ_BYTE: d.reg_wdata = {{24{MEM_RDATA[7]}}, MEM_RDATA[7:0]};
          SZ_WORD: d.reg_wdata = {{16{MEM_RDATA[15]}}, MEM_RDATA[15:0]};
          default: d.reg_wdata = MEM_RDATA;
        endcase
        d.st = S_IDLE;
      end
      S_RMW_RD: begin
        if (q.rmw_op == 2'h0) begin
          d.flag = ((MEM_RDATA[7:0] & q.lit) == 8'h00);
        end else begin
          d.mem_req   = 1'b1;
          d.mem_we    = 1'b1;
          d.mem_wdata = {24'h000000, rmw_res};
        end
        d.st = S_RMW_WR;
      end
      S_RMW_WR: begin
        d.st = S_IDLE;
      end
      S_WAIT: begin
        d.cnt = q.cnt - ST_ONE;
        if (q.cnt == ST_ONE) begin
          d.st = S_IDLE;
        end
      end
      S_TRAP: begin
        d.cnt = q.cnt + ST_ONE;
        if (q.cnt == ST_ONE) begin
          d.mem_req   = 1'b1;
          d.mem_we    = 1'b1;
          d.mem_addr  = STACK_PTR - (LONG_STEP << 1);
          d.mem_wdata = q.tmp;
          d.sp_we     = 1'b1;
          d.sp_wdata  = STACK_PTR - (LONG_STEP << 1);
        end else if (q.cnt == 4'h2) begin
          d.mem_req  = 1'b1;
          d.mem_addr = VECTOR_BASE + ({24'h000000, q.lit} << 2);
        end else if (q.cnt == 4'h4) begin
          d.pc_we    = 1'b1;
          d.pc_wdata = MEM_RDATA;
        end
        if (q.cnt == ST_TRAP - ST_ONE) begin
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
    // Busy is registered so that the output comes straight from a flip-flop.
    d.busy = (d.st != S_IDLE);
  end

  // State register; the flag and all strobes clear on reset.
  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign MEM_REQ    = q.mem_req;
  assign MEM_WE     = q.mem_we;
  assign MEM_SIZE   = q.mem_size;
  assign MEM_ADDR   = q.mem_addr;
  assign MEM_WDATA  = q.mem_wdata;
  assign REG_WE     = q.reg_we;
  assign REG_IDX    = q.reg_idx;
  assign REG_WDATA  = q.reg_wdata;
  assign RET_WE     = q.ret_we;
  assign RET_WDATA  = q.ret_wdata;
  assign SP_WE      = q.sp_we;
  assign SP_WDATA   = q.sp_wdata;
  assign PC_WE      = q.pc_we;
  assign PC_WDATA   = q.pc_wdata;
  assign DELAY_SLOT = q.delay_slot;
  assign FLAG_Q     = q.flag;
  assign BUSY       = q.busy;
  assign ILLEGAL    = q.illegal;

  // Checks.
  property p_rmw_three;
    @(posedge CLK) disable iff (RST) (INSN_VALID && !BUSY && hi8 == OPC_AND_MEM)
      |=> BUSY ##1 BUSY ##1 !BUSY;
  endproperty
  a_rmw_three: assert property (p_rmw_three) else $error("rmw not three states");
  property p_test_nowrite;
    @(posedge CLK) disable iff (RST) (INSN_VALID && !BUSY && hi8 == OPC_TST_MEM)
      |=> ##1 !MEM_WE;
  endproperty
  a_test_nowrite: assert property (p_test_nowrite) else $error("byte test wrote");
  property p_cmp;
    @(posedge CLK) disable iff (RST) (INSN_VALID && !BUSY && hi8 == OPC_COMPARE_EQUAL)
      |=> FLAG_Q == $past(ZERO_VAL == lit_s);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag wrong");
  property p_jump_disp;
    @(posedge CLK) disable iff (RST) (INSN_VALID && !BUSY && INSN[15:12] == OPC_JUMP_DISP)
      |=> PC_WE && DELAY_SLOT && $stable(FLAG_Q) ##1 !BUSY;
  endproperty
  a_jump_disp: assert property (p_jump_disp) else $error("jump not two states");
  property p_trap;
    @(posedge CLK) disable iff (RST) (INSN_VALID && !BUSY && hi8 == OPC_TRAP)
      |=> BUSY [*7] ##1 !BUSY;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not eight states");
  property p_true_skip;
    @(posedge CLK) disable iff (RST) (INSN_VALID && !BUSY && hi8 == OPC_BR_T && !FLAG_Q)
      |=> !PC_WE && !BUSY;
  endproperty
  a_true_skip: assert property (p_true_skip) else $error("untaken branch slow");
  property p_true_taken;
    @(posedge CLK) disable iff (RST) (INSN_VALID && !BUSY && hi8 == OPC_BR_T && FLAG_Q)
      |=> PC_WE ##1 BUSY ##1 !BUSY;
  endproperty
  a_true_taken: assert property (p_true_taken) else $error("taken branch not three");
  property p_idx_st;
    @(posedge CLK) disable iff (RST)
      (INSN_VALID && !BUSY && (INSN & OPC_IDX_MASK) == OPC_ST_IDX_L)
      |=> MEM_WE && MEM_ADDR == $past(ZERO_VAL + TARGET_VAL) && !BUSY;
  endproperty
  a_idx_st: assert property (p_idx_st) else $error("indexed store wrong");
  c_trap: cover property (@(posedge CLK) disable iff (RST) PC_WE && BUSY);
  c_rmw: cover property (@(posedge CLK) disable iff (RST) MEM_WE && q.st == S_RMW_WR);
  c_load: cover property (@(posedge CLK) disable iff (RST) REG_WE && REG_IDX == IDX_ZERO);
endmodule : rmode_decode
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking testbench for the addressing-mode decode unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rmode_pkg::*;
  // Stimulus, driven on the rising edge.
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vld = 1'b0;
  logic [15:0] insn = 16'h0000;
  logic [31:0] pc = 32'h0000_1000;
  logic [31:0] src = 32'h0000_0040;
  logic [31:0] tgt = 32'h0000_0020;
  logic [31:0] zr = 32'h0000_0100;
  logic [31:0] gb = 32'h0000_2000;
  logic [31:0] vb = 32'h0000_4000;
  logic [31:0] sp = 32'h0000_8000;
  logic [31:0] st = 32'h0000_00F0;
  logic [31:0] rd = 32'h0000_8080;
  // Observed outputs.
  logic        mreq, mwe, rwe, retwe, spwe, pcwe, dly, flag, busy, ill;
  logic [1:0]  msz;
  logic [3:0]  ridx;
  logic [31:0] maddr, mwd, rwd, retwd, spwd, pcwd;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  rmode_decode dut (
    .CLK(clk), .RST(rst), .INSN_VALID(vld), .INSN(insn), .PC_IN(pc),
    .SOURCE_VAL(src), .TARGET_VAL(tgt), .ZERO_VAL(zr), .GLOBAL_BASE(gb),
    .VECTOR_BASE(vb), .STACK_PTR(sp), .STATUS_VAL(st), .MEM_RDATA(rd),
    .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_SIZE(msz), .MEM_ADDR(maddr),
    .MEM_WDATA(mwd), .REG_WE(rwe), .REG_IDX(ridx), .REG_WDATA(rwd),
    .RET_WE(retwe), .RET_WDATA(retwd), .SP_WE(spwe), .SP_WDATA(spwd),
    .PC_WE(pcwe), .PC_WDATA(pcwd), .DELAY_SLOT(dly), .FLAG_Q(flag),
    .BUSY(busy), .ILLEGAL(ill)
  );

  // The older variant sees the same stimulus; only its refusal outputs are judged.
  logic        old_pcwe, old_ill;
  rmode_decode #(.NEWER_VARIANT(1'b0)) dut_old (
    .CLK(clk), .RST(rst), .INSN_VALID(vld), .INSN(insn), .PC_IN(pc),
    .SOURCE_VAL(src), .TARGET_VAL(tgt), .ZERO_VAL(zr), .GLOBAL_BASE(gb),
    .VECTOR_BASE(vb), .STACK_PTR(sp), .STATUS_VAL(st), .MEM_RDATA(rd),
    .MEM_REQ(), .MEM_WE(), .MEM_SIZE(), .MEM_ADDR(), .MEM_WDATA(), .REG_WE(),
    .REG_IDX(), .REG_WDATA(), .RET_WE(), .RET_WDATA(), .SP_WE(), .SP_WDATA(),
    .PC_WE(old_pcwe), .PC_WDATA(), .DELAY_SLOT(), .FLAG_Q(), .BUSY(),
    .ILLEGAL(old_ill)
  );

  // A 5 ns clock.
  always #2.5 clk = ~clk;

  // A hang is cut short well beyond the roughly 120 cycles the tests need.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Single-bit outputs go through the same comparison.
  task automatic cb(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask : cb

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Offers one opcode and returns once the first answer cycle has settled.
  task automatic issue(input logic [15:0] op);
    @(posedge clk);
    vld  <= 1'b1;
    insn <= op;
    @(posedge clk);
    vld <= 1'b0;
    // The opcode is taken at this edge; its one-cycle strobes stand until the next.
    #1;
  endtask : issue

  task automatic t_imm;
    logic [7:0]  ops [3] = '{OPC_AND_IMM, OPC_OR_IMM, OPC_XOR_IMM};
    logic [31:0] ex [3] = '{32'h0000_0030, 32'h1234_56FC, 32'h1234_56CC};
    @(posedge clk);
    tgt <= 32'h0000_0005;
    zr  <= 32'h1234_56F0;
    issue({OPC_ADD_IMM, 4'h3, 8'hFF});
    chk("add sum", rwd, 32'h0000_0004);
    cb("add we", rwe, 1'b1);
    chk("add idx", {28'h0, ridx}, 32'h0000_0003);
    issue({OPC_MOV_IMM, 4'h2, 8'h80});
    chk("mov val", rwd, 32'hFFFF_FF80);
    issue({OPC_TST_IMM, 8'h0F});
    cb("tst flag", flag, 1'b1);
    for (int i = 0; i < 3; i++) begin
      issue({ops[i], 8'h3C});
      chk("logic val", rwd, ex[i]);
      cb("logic flag", flag, 1'b1);
    end
    issue({OPC_TST_IMM, 8'h10});
    cb("tst clear", flag, 1'b0);
    $display("end of immediate test");
  endtask : t_imm

  // Indexed and base-relative transfers for every access size.
  task automatic t_mem;
    logic [31:0] ext [3] = '{32'hFFFF_FF80, 32'hFFFF_8080, 32'h0000_8080};
    @(posedge clk);
    zr  <= 32'h0000_0100;
    tgt <= 32'h0000_0020;
    for (int s = 0; s < 3; s++) begin
      issue({12'h012, 4'(4 + s)});
      chk("ix st addr", maddr, 32'h0000_0120);
      chk("ix st data", mwd, src);
      cb("ix st we", mwe, 1'b1);
      chk("ix st size", {30'h0, msz}, 32'(s));
      issue({12'h012, 4'(12 + s)});
      chk("ix ld addr", maddr, 32'h0000_0140);
      step(1);
      chk("ix ld data", rwd, ext[s]);
      chk("ix ld idx", {28'h0, ridx}, 32'h0000_0001);
      issue({8'(OPC_ST_GB_B + s), 8'h10});
      chk("gb st addr", maddr, 32'h0000_2000 + (32'h0000_0010 << s));
      chk("gb st data", mwd, 32'h0000_0100);
      chk("gb st size", {30'h0, msz}, 32'(s));
      issue({8'(OPC_LD_GB_B + s), 8'h10});
      chk("gb ld addr", maddr, 32'h0000_2000 + (32'h0000_0010 << s));
      step(1);
      chk("gb ld data", rwd, ext[s]);
      chk("gb ld idx", {28'h0, ridx}, 32'h0000_0000);
    end
    $display("end of transfer test");
  endtask : t_mem

  // The test form runs first, so the flag must come up and then stay.
  task automatic t_rmw;
    logic [7:0] ops [4] = '{OPC_TST_MEM, OPC_AND_MEM, OPC_XOR_MEM, OPC_OR_MEM};
    logic [7:0] lit [4] = '{8'h0F, 8'h3C, 8'h3C, 8'h3C};
    logic [7:0] ex [4] = '{8'h00, 8'h30, 8'hCC, 8'hFC};
    @(posedge clk);
    zr <= 32'h0000_0004;
    gb <= 32'h0000_3000;
    rd <= 32'h0000_00F0;
    for (int i = 0; i < 4; i++) begin
      issue({ops[i], lit[i]});
      chk("rmw addr", maddr, 32'h0000_3004);
      cb("rmw read", mwe, 1'b0);
      step(1);
      cb("rmw write", mwe, i != 0);
      if (i != 0) begin
        chk("rmw data", {24'h0, mwd[7:0]}, {24'h0, ex[i]});
      end
      step(1);
      cb("rmw busy", busy, 1'b0);
      cb("rmw flag", flag, 1'b1);
    end
    $display("end of modify test");
  endtask : t_rmw

  task automatic t_pcrel;
    @(posedge clk);
    rd <= 32'h0000_8080;
    issue({OPC_LD_PC_W, 4'h5, 8'h10});
    chk("pcw addr", maddr, 32'h0000_1020);
    step(1);
    chk("pcw data", rwd, 32'hFFFF_8080);
    issue({OPC_LD_PC_L, 4'h6, 8'h80});
    chk("pcl addr", maddr, 32'h0000_1200);
    step(1);
    chk("pcl data", rwd, 32'h0000_8080);
    issue({OPC_ADDR_LIT, 8'h80});
    chk("lit val", rwd, 32'h0000_1200);
    cb("lit mem", mreq, 1'b0);
    $display("end of relative load test");
  endtask : t_pcrel

  task automatic t_flow;
    @(posedge clk);
    tgt <= 32'h0000_0100;
    zr  <= 32'h0000_0012;
    issue(16'hAFFF);
    chk("jump pc", pcwd, 32'h0000_0FFE);
    cb("jump slot", dly, 1'b1);
    step(1);
    cb("jump busy", busy, 1'b0);
    issue(16'hB004);
    chk("call pc", pcwd, 32'h0000_1008);
    chk("call ret", retwd, 32'h0000_1000);
    step(1);
    issue(16'h0323);
    chk("reg jump pc", pcwd, 32'h0000_1100);
    cb("reg jump ok", ill, 1'b0);
    cb("old reg jump", old_ill, 1'b1);
    cb("old reg no pc", old_pcwe, 1'b0);
    step(1);
    issue(16'h0303);
    cb("reg call ret", retwe, 1'b1);
    step(1);
    issue({OPC_COMPARE_EQUAL, 8'h12});
    cb("cmp flag", flag, 1'b1);
    issue({OPC_BR_T, 8'h04});
    chk("cond pc", pcwd, 32'h0000_1008);
    cb("cond slot", dly, 1'b0);
    step(1);
    cb("cond busy", busy, 1'b1);
    step(1);
    cb("cond done", busy, 1'b0);
    issue({OPC_BR_F, 8'h04});
    cb("cond skip", pcwe, 1'b0);
    issue({OPC_BR_T_DLY, 8'hFE});
    chk("dcond pc", pcwd, 32'h0000_0FFC);
    cb("dcond slot", dly, 1'b1);
    cb("old dcond", old_ill, 1'b1);
    step(1);
    cb("dcond done", busy, 1'b0);
    $display("end of branch test");
  endtask : t_flow

  task automatic t_trap;
    @(posedge clk);
    rd <= 32'h0000_6000;
    issue({OPC_TRAP, 8'h05});
    chk("trap st addr", maddr, 32'h0000_7FFC);
    chk("trap st data", mwd, 32'h0000_00F0);
    step(1);
    chk("trap pc addr", maddr, 32'h0000_7FF8);
    chk("trap pc data", mwd, 32'h0000_1000);
    cb("trap sp we", spwe, 1'b1);
    step(1);
    chk("trap vector", maddr, 32'h0000_4014);
    step(2);
    cb("trap jump we", pcwe, 1'b1);
    chk("trap jump", pcwd, 32'h0000_6000);
    chk("trap sp", spwd, 32'h0000_7FF8);
    step(3);
    cb("trap busy", busy, 1'b0);
    $display("end of trap test");
  endtask : t_trap

  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // Reset is held for sixteen cycles, then the scenarios run in turn.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_imm();
    t_mem();
    t_rmw();
    t_pcrel();
    t_flow();
    t_trap();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
